//--- dv/rtcpa_props.sv
// port-level assertion checker for the prescaled alarm clock
`timescale 1ns/1ps
module rtcpa_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire rtcpa_pkg::rtcpa_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic powerdown,
    input wire logic tick_interrupt_request,
    input wire logic alarm_interrupt_request,
    input wire logic cyclic_interrupt_request,
    input wire rtcpa_pkg::rtcpa_power_t power
);
    import rtcpa_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // holes in the map: past the last register or not word aligned
    wire unmapped = bus_req.addr > ADDR_SYSCFG || bus_req.addr[1:0] != 2'h0;
    a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
        else $error("read data outside a read");
    a_unmapped_zero: assert property (bus_req.rd && unmapped |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_reload_width: assert property (bus_req.rd && bus_req.addr == ADDR_RELOAD |=> bus_rdata[31:20] == 12'h0)
        else $error("reload wider than 20 bits");
    // flags only drop on a bus write (clear or enable change)
    a_tick_sticky: assert property (tick_interrupt_request && !bus_req.wr |=> tick_interrupt_request)
        else $error("tick request dropped");
    a_alarm_sticky: assert property (alarm_interrupt_request && !bus_req.wr |=> alarm_interrupt_request)
        else $error("alarm request dropped");
    a_cyc_sticky: assert property (cyclic_interrupt_request && !bus_req.wr |=> cyclic_interrupt_request)
        else $error("cyclic request dropped");
    // at least 64 steps per tick, so no new tick right after one
    a_tick_spacing: assert property ($rose(tick_interrupt_request) |=> !$rose(tick_interrupt_request) [*8])
        else $error("ticks too close");
    a_osc_awake: assert property (!powerdown [*2] |-> power.osc_main_en && power.osc_lp_en)
        else $error("oscillator off outside power-down");
    c_tick: cover property ($rose(tick_interrupt_request));
    c_alarm: cover property ($rose(alarm_interrupt_request));
    c_main_off: cover property ($fell(power.osc_main_en));
endmodule
bind rtcpa_top rtcpa_props rtcpa_props_inst (.clk, .sys_rst, .bus_req, .bus_rdata, .powerdown,
    .tick_interrupt_request, .alarm_interrupt_request, .cyclic_interrupt_request, .power);

//--- dv/testbench.sv
// self-checking bench for the prescaled alarm clock
`timescale 1ns/1ps
module testbench;
    import rtcpa_pkg::*;
    logic clk, sys_rst, lpin, powerdown, idle, t_irq, a_irq, c_irq, al, cy;
    rtcpa_bus_req_t bus_req;
    rtcpa_power_t pwr;
    logic [31:0] rdata, mt, seed;
    int n_fail = 0, compares = 0, cyc_now = 0, last_t, n, r, k, nc;
    logic [7:0] pc [3] = '{8'h00, 8'h11, 8'h01};
    logic [1:0] pe [3] = '{2'b00, 2'b00, 2'b11};
    rtcpa_top rtcpa_top_inst (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(rdata),
        .low_power_oscillator_input(lpin), .powerdown(powerdown), .idle(idle), .tick_interrupt_request(t_irq),
        .alarm_interrupt_request(a_irq), .cyclic_interrupt_request(c_irq), .power(pwr));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // free cycle count for measuring tick periods
    always @(posedge clk) cyc_now <= cyc_now + 1;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one idle cycle after each strobe keeps drivers single per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
        @(posedge clk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1 chk(nm, rdata, exp);
        @(posedge clk);
    endtask
    // wait for a tick flag, then sample alarm and cyclic a little later
    task automatic wait_tick(input int per);
        int i;
        #1;
        for (i = 0; i < 400 && t_irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("tick_seen", {31'h0, t_irq}, 32'h1);
        if (per > 0) chk("tick_period", 32'(cyc_now - last_t), 32'(per));
        last_t = cyc_now;
        mt++;
        repeat (2) @(posedge clk);
        #1;
        al = a_irq;
        cy = c_irq;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        n_fail++;
        end_sim();
    end
    initial begin
        bus_req = '0;
        lpin = 0;
        powerdown = 0;
        idle = 0;
        sys_rst = 1;
        seed = $urandom(32'h42f604f6);
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        rdc("ctrl", ADDR_CTRL, 32'h1);
        rdc("reload", ADDR_RELOAD, 32'h0);
        rdc("alarm", ADDR_ALARM, 32'hffffffff);
        rdc("cycn", ADDR_CYCN, 32'h1);
        wr(8'h20, 32'h7f);
        rdc("unmapped", 8'h20, 32'h0);
        rdc("ctrl_kept", ADDR_CTRL, 32'h1);
        $display("test reset_map done");
        // count across the wrap into an alarm at zero
        r = $urandom_range(3, 0);
        wr(ADDR_RELOAD, 32'(r));
        rdc("reload_rb", ADDR_RELOAD, 32'(r));
        wr(ADDR_CTRL, 32'hf);
        wr(ADDR_STATUS, 32'h7);
        wait_tick(0);
        wr(ADDR_TIME, 32'hfffffffe);
        wr(ADDR_ALARM, 32'h0);
        wr(ADDR_STATUS, 32'h7);
        mt = 32'hfffffffe;
        for (k = 0; k < 4; k++) begin
            wait_tick(64 * (r + 1));
            rdc("time", ADDR_TIME, mt);
            chk("alarm_irq", {31'h0, al}, {31'h0, mt == 32'h0});
            chk("cyc_irq", {31'h0, cy}, 32'h1);
            wr(ADDR_STATUS, 32'h7);
        end
        $display("test count_alarm done");
        // cyclic every n ticks over a multiple of n
        n = $urandom_range(4, 2);
        wr(ADDR_CYCN, 32'(n));
        wr(ADDR_CTRL, 32'h47);
        wr(ADDR_STATUS, 32'h7);
        nc = 0;
        for (k = 0; k < 12; k++) begin
            wait_tick(64 * (r + 1));
            nc += (cy === 1'b1);
            wr(ADDR_STATUS, 32'h7);
        end
        chk("cyc_count", 32'(nc), 32'(12 / n));
        $display("test cyclic done");
        // oscillator enables in power-down per control setting
        foreach (pc[i]) begin
            wr(ADDR_CTRL, {24'h0, pc[i]});
            powerdown <= 1;
            repeat (3) @(posedge clk);
            #1 chk("osc", {30'h0, pwr.osc_main_en, pwr.osc_lp_en}, {30'h0, pe[i]});
            @(posedge clk);
            powerdown <= 0;
            @(posedge clk);
        end
        // tick routed to the external wake path while powered down and allowed to run
        wr(ADDR_SYSCFG, 32'h3);
        wr(ADDR_CTRL, 32'h23);
        wr(ADDR_STATUS, 32'h7);
        powerdown <= 1;
        wait_tick(0);
        chk("exi_irq", {31'h0, pwr.exi_irq}, 32'h1);
        chk("wake", {31'h0, pwr.wake}, 32'h1);
        powerdown <= 0;
        @(posedge clk);
        $display("test power done");
        end_sim();
    end
endmodule

//--- shared/rtcpa_pkg.sv
// package for the prescaled alarm real-time clock: register map, fields, reset values
package rtcpa_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RELOAD = 8'h08;
    localparam logic [7:0] ADDR_TIME = 8'h0c;
    localparam logic [7:0] ADDR_ALARM = 8'h10;
    localparam logic [7:0] ADDR_CYCN = 8'h14;
    localparam logic [7:0] ADDR_DIVCNT = 8'h18;
    localparam logic [7:0] ADDR_SYSCFG = 8'h1c;
    // control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_TICK_EN = 1;
    localparam int CTRL_CYC_EN = 2;
    localparam int CTRL_ALARM_EN = 3;
    localparam int CTRL_OSC_OFF = 4;
    localparam int CTRL_IDLE_RUN = 5;
    localparam int CTRL_CYCN_EN = 6;
    localparam logic [6:0] CTRL_RESET = 7'h01;
    // status fields (flags write one to clear, ST_LP_SRC read-only)
    localparam int ST_TICK = 0;
    localparam int ST_CYC = 1;
    localparam int ST_ALARM = 2;
    localparam int ST_LP_SRC = 3;
    // system configuration fields
    localparam int SYS_PWD_WAKE = 0;
    localparam int SYS_EXI_TICK = 1;
    localparam int SYS_EXI_ALARM = 2;
    // widths and reset values
    localparam int PRE_W = 6;
    localparam int DIV_W = 20;
    localparam int CNT_W = 32;
    localparam logic [5:0] PRE_LAST = 6'h3f;
    localparam logic [19:0] RELOAD_RESET = 20'h00000;
    localparam logic [31:0] CYCN_RESET = 32'h00000001;
    // low-power oscillator detection: edges needed inside the window
    localparam int DET_EDGES = 4;
    localparam logic [15:0] DET_WINDOW = 16'hffff;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rtcpa_bus_req_t;

    typedef struct packed {
        logic osc_main_en;
        logic osc_lp_en;
        logic wake;
        logic exi_irq;
    } rtcpa_power_t;
endpackage

//--- verilog/rtcpa_top.sv
// prescaled alarm real-time clock with power-down oscillator control
`timescale 1ns/1ps
// How it works
// - clock from main or 32 kHz, run in idle
// - fixed divide by sixty-four feeds divider
// - divider reloads from reload register each tick
// - tick period set by reload value
// - tick request once per period when enabled
// - cyclic request every tick, or every n ticks when enabled
// - 32-bit time counter, preloadable, counts ticks
// - compare counter with 32-bit alarm register
// - alarm request when counter equals alarm
// - prescaler plus counter form 58-bit timer
// - tick and alarm drive external wake interrupt
// - power-down wake only with wake config bit
// - oscillator off in power-down when bit set
// - both oscillators stop in power-down when timer disabled
// - detect 32 kHz presence after every reset
// - main oscillator off in power-down when 32 kHz drives
// - else main oscillator kept running unless disabled
// - registers reached only through the bus port
module rtcpa_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire rtcpa_pkg::rtcpa_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input wire logic low_power_oscillator_input,
    input wire logic powerdown,
    input wire logic idle,
    output logic tick_interrupt_request,
    output logic alarm_interrupt_request,
    output logic cyclic_interrupt_request,
    output rtcpa_pkg::rtcpa_power_t power
);
    import rtcpa_pkg::*;

    logic [6:0] ctrl_q;
    logic [2:0] flags_q;
    logic [19:0] reload_q;
    logic [31:0] time_q;
    logic [31:0] alarm_q;
    logic [31:0] cycn_q;
    logic [31:0] cyccnt_q;
    logic [5:0] pre_q;
    logic [19:0] div_q;
    logic [2:0] sys_q;
    logic [31:0] rdata_q;
    logic lp_sync1_q;
    logic lp_sync2_q;
    logic lp_prev_q;
    logic [15:0] det_cnt_q;
    logic [2:0] det_edges_q;
    logic det_busy_q;
    logic lp_src_q;
    logic tick_irq_q;
    logic alarm_irq_q;
    logic cyc_irq_q;
    logic alarm_hit_q;
    logic wake_q;
    logic lp_tick_q;

    // bus decode; only this port reaches the registers
    wire wr_ctrl = bus_req.wr && bus_req.addr == ADDR_CTRL;
    wire wr_status = bus_req.wr && bus_req.addr == ADDR_STATUS;
    wire wr_reload = bus_req.wr && bus_req.addr == ADDR_RELOAD;
    wire wr_time = bus_req.wr && bus_req.addr == ADDR_TIME;
    wire wr_alarm = bus_req.wr && bus_req.addr == ADDR_ALARM;
    wire wr_cycn = bus_req.wr && bus_req.addr == ADDR_CYCN;
    wire wr_sys = bus_req.wr && bus_req.addr == ADDR_SYSCFG;

    // counting is allowed unless parked by idle or power-down without permission
    wire parked = (idle || powerdown) && !ctrl_q[CTRL_IDLE_RUN];
    wire run = ctrl_q[CTRL_RUN] && !parked;
    // low-power source: one tick of the prescaler per rising 32 kHz edge, else every clk
    wire lp_edge = lp_sync2_q && !lp_prev_q;
    wire src_step = lp_src_q ? lp_tick_q : 1'b1;
    wire pre_step = run && src_step;
    wire pre_wrap = pre_step && pre_q == PRE_LAST;
    wire div_wrap = pre_wrap && div_q == 20'h00000;
    wire tick = div_wrap;
    wire time_hit = time_q == alarm_q;
    wire alarm_evt = time_hit && !alarm_hit_q;
    wire cycn_done = tick && cyccnt_q + 32'h00000001 >= cycn_q;
    wire cyc_evt = tick && (!ctrl_q[CTRL_CYCN_EN] || cycn_done);
    // hardware set wins over a simultaneous software clear
    wire [2:0] set_v = {alarm_evt, cyc_evt, tick};
    wire [2:0] clr_v = wr_status ? bus_req.wdata[2:0] : 3'h0;
    wire [2:0] flags_d = (flags_q & ~clr_v) | set_v;
    wire [57:0] long_timer = {time_q, div_q, pre_q};

    // read data mux, unmapped reads zero
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (bus_req.addr)
            ADDR_CTRL: rdata_d = {25'h0, ctrl_q};
            ADDR_STATUS: rdata_d = {28'h0, lp_src_q, flags_q};
            ADDR_RELOAD: rdata_d = {12'h0, reload_q};
            ADDR_TIME: rdata_d = time_q;
            ADDR_ALARM: rdata_d = alarm_q;
            ADDR_CYCN: rdata_d = cycn_q;
            ADDR_DIVCNT: rdata_d = {6'h0, long_timer[25:0]};
            ADDR_SYSCFG: rdata_d = {29'h0, sys_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // register file writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
            reload_q <= RELOAD_RESET;
            alarm_q <= 32'hffffffff;
            cycn_q <= CYCN_RESET;
            sys_q <= 3'h0;
            rdata_q <= 32'h00000000;
        end else begin
            if (wr_ctrl) ctrl_q <= bus_req.wdata[6:0];
            if (wr_reload) reload_q <= bus_req.wdata[19:0];
            if (wr_alarm) alarm_q <= bus_req.wdata;
            if (wr_cycn) cycn_q <= bus_req.wdata;
            if (wr_sys) sys_q <= bus_req.wdata[2:0];
            rdata_q <= bus_req.rd ? rdata_d : 32'h00000000;
        end
    end

    // prescaler chain: fixed by-64, then reloading 20-bit down counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_q <= 6'h00;
            div_q <= RELOAD_RESET;
        end else begin
            if (pre_step) pre_q <= pre_q + 6'h01;
            if (wr_reload) div_q <= bus_req.wdata[19:0];
            else if (div_wrap) div_q <= reload_q;
            else if (pre_wrap) div_q <= div_q - 20'h00001;
        end
    end

    // time counter and cyclic counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            time_q <= 32'h00000000;
            cyccnt_q <= 32'h00000000;
            alarm_hit_q <= 1'b0;
        end else begin
            if (wr_time) time_q <= bus_req.wdata;
            else if (tick) time_q <= time_q + 32'h00000001;
            if (wr_cycn || cyc_evt) cyccnt_q <= 32'h00000000;
            else if (tick) cyccnt_q <= cyccnt_q + 32'h00000001;
            alarm_hit_q <= time_hit; // one event per match, not per cycle
        end
    end

    // sticky flags and gated request outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q <= 3'h0;
            tick_irq_q <= 1'b0;
            cyc_irq_q <= 1'b0;
            alarm_irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            tick_irq_q <= flags_d[ST_TICK] && ctrl_q[CTRL_TICK_EN];
            cyc_irq_q <= flags_d[ST_CYC] && ctrl_q[CTRL_CYC_EN];
            alarm_irq_q <= flags_d[ST_ALARM] && ctrl_q[CTRL_ALARM_EN];
        end
    end

    // 32 kHz synchroniser and edge detector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lp_sync1_q <= 1'b0;
            lp_sync2_q <= 1'b0;
            lp_prev_q <= 1'b0;
            lp_tick_q <= 1'b0;
        end else begin
            lp_sync1_q <= low_power_oscillator_input;
            lp_sync2_q <= lp_sync1_q;
            lp_prev_q <= lp_sync2_q;
            lp_tick_q <= lp_edge;
        end
    end

    // presence detection restarts at every reset; window counted in clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            det_cnt_q <= 16'h0000;
            det_edges_q <= 3'h0;
            det_busy_q <= 1'b1;
            lp_src_q <= 1'b0;
        end else if (det_busy_q) begin
            det_cnt_q <= det_cnt_q + 16'h0001;
            if (lp_edge && det_edges_q != 3'(DET_EDGES)) det_edges_q <= det_edges_q + 3'h1;
            if (det_edges_q == 3'(DET_EDGES)) begin
                lp_src_q <= 1'b1;
                det_busy_q <= 1'b0;
            end else if (det_cnt_q == DET_WINDOW) begin
                det_busy_q <= 1'b0;
            end
        end
    end

    // oscillator enables and wake logic; slow clk limits tick rate from low source
    wire exi_src = (sys_q[SYS_EXI_TICK] && tick_irq_q) || (sys_q[SYS_EXI_ALARM] && alarm_irq_q);
    wire timer_on = ctrl_q[CTRL_RUN];
    wire osc_off = powerdown && ctrl_q[CTRL_OSC_OFF];
    wire main_en_d = !powerdown || (!lp_src_q && timer_on && !ctrl_q[CTRL_OSC_OFF]);
    wire lp_en_d = !powerdown || (timer_on && !osc_off);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wake_q <= 1'b0;
            power <= '{osc_main_en: 1'b1, osc_lp_en: 1'b1, wake: 1'b0, exi_irq: 1'b0};
        end else begin
            wake_q <= powerdown && exi_src && sys_q[SYS_PWD_WAKE];
            power.osc_main_en <= main_en_d;
            power.osc_lp_en <= lp_en_d;
            power.wake <= wake_q;
            power.exi_irq <= exi_src;
        end
    end

    assign bus_rdata = rdata_q;
    assign tick_interrupt_request = tick_irq_q;
    assign alarm_interrupt_request = alarm_irq_q;
    assign cyclic_interrupt_request = cyc_irq_q;
endmodule
